// ### slcr_defs.svh
// Purpose: Constants of the synthesizer loop configuration register bank.
// Assumes: 24-bit serial words with the register address in bits 3:0.
// Notes:   Field positions, addresses and reset values only.
`ifndef SLCR_DEFS_SVH
`define SLCR_DEFS_SVH

// Address nibble of each serial word.
`define SLCR_ADDR_MSB        3
`define SLCR_ADDR_LSB        0
`define SLCR_ADDR_LOOP_CFG   4'h9
`define SLCR_ADDR_EXT_FRAC   4'hb
`define SLCR_ADDR_FREQ_WORD  4'h0

// Loop configuration word fields.
`define SLCR_AUTO_PU_BIT     23
`define SLCR_DITHER_MSB      17
`define SLCR_DITHER_LSB      16
`define SLCR_ORDER_MSB       15
`define SLCR_ORDER_LSB       14
`define SLCR_DOUBLER_BIT     12
`define SLCR_REFBUF_BIT      11
`define SLCR_AUXPOL_BIT      10
`define SLCR_MAINPOL_BIT     9
`define SLCR_PRESC_BIT       8
`define SLCR_OUTSEL_MSB      7
`define SLCR_OUTSEL_LSB      4
`define SLCR_FIXED_MASK      24'h7c2000
`define SLCR_FIXED_VALUE     24'h200000

// Extended fraction word fields.
`define SLCR_DEN_MSB         23
`define SLCR_DEN_LSB         14
`define SLCR_NUM_MSB         13
`define SLCR_NUM_LSB         4

// Reset values.
`define SLCR_RST_AUTO_PU     1'h0
`define SLCR_RST_DITHER      2'h2
`define SLCR_RST_ORDER       2'h3
`define SLCR_RST_DOUBLER     1'h0
`define SLCR_RST_REFBUF      1'h0
`define SLCR_RST_AUXPOL      1'h1
`define SLCR_RST_MAINPOL     1'h1
`define SLCR_RST_PRESC       1'h1
`define SLCR_RST_OUTSEL      4'h0
`define SLCR_RST_FRAC        10'h000

`endif

// ### slcr_pkg.sv
// Purpose: Types shared by the loop configuration register bank.
// Assumes: Nothing beyond the constants header.
// Notes:   Enumerations follow the field encodings.
package slcr_pkg;

    typedef enum logic [1:0] {
        SLCR_ORDER4 = 2'h0,
        SLCR_BYPASS = 2'h1,
        SLCR_ORDER2 = 2'h2,
        SLCR_ORDER3 = 2'h3
    } slcr_order_t;

    typedef enum logic [1:0] {
        SLCR_SPUR_SPREAD_SEL_OFF    = 2'h0,
        SLCR_SPUR_SPREAD_SEL_WEAK   = 2'h1,
        SLCR_SPUR_SPREAD_SEL_STRONG = 2'h2,
        SLCR_SPUR_SPREAD_SEL_RSVD   = 2'h3
    } slcr_dither_t;

    typedef enum logic [3:0] {
        SLCR_SEL_HIZ      = 4'h0, SLCR_SEL_HIGH     = 4'h1,
        SLCR_SEL_LOW      = 4'h2, SLCR_SEL_DL_BOTH  = 4'h3,
        SLCR_SEL_DL_MAIN  = 4'h4, SLCR_SEL_DL_AUX   = 4'h5,
        SLCR_SEL_AOD_BOTH = 4'h6, SLCR_SEL_AOD_MAIN = 4'h7,
        SLCR_SEL_AOD_AUX  = 4'h8, SLCR_SEL_APP_BOTH = 4'h9,
        SLCR_SEL_APP_MAIN = 4'ha, SLCR_SEL_APP_AUX  = 4'hb,
        SLCR_SEL_AUX_REF  = 4'hc, SLCR_SEL_AUX_FB   = 4'hd,
        SLCR_SEL_MAIN_REF = 4'he, SLCR_SEL_MAIN_FB  = 4'hf
    } slcr_sel_t;

    typedef struct packed {
        logic         auto_pu;
        slcr_dither_t dither;
        slcr_order_t  order;
        logic         doubler;
        logic         ref_buf;
        logic         aux_pol;
        logic         main_pol;
        logic         presc;
        slcr_sel_t    out_sel;
    } slcr_cfg_t;

    typedef struct packed {
        logic main_dig;
        logic aux_dig;
        logic main_ana;
        logic aux_ana;
    } slcr_lock_t;

    // Index order matches selector codes 12 to 15.
    typedef struct packed {
        logic main_fb;
        logic main_ref;
        logic aux_fb;
        logic aux_ref;
    } slcr_div_t;

endpackage

// ### slcr_pin_mux.sv
// Purpose: Drives the test and lock indication pin from its selector.
// Assumes: Lock levels and divider pulses are synchronous to clk.
// Notes:   Divider copies toggle once per divider output pulse.
`timescale 1ns/1ps
module slcr_pin_mux (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               rst,
    // Selector and sources.
    input  wire slcr_pkg::slcr_sel_t sel,
    input  wire slcr_pkg::slcr_lock_t lock,
    input  wire slcr_pkg::slcr_div_t  div_pulse,
    // Pin.
    output logic                    pin_o,
    output logic                    pin_oe
);
    logic [3:0] half_q;
    logic [3:0] half_d;
    logic       pin_o_d;
    logic       pin_oe_d;

    always_comb begin
        half_d = half_q ^ div_pulse;
        pin_o_d  = 1'h0;
        pin_oe_d = 1'h1;
        unique case (sel)
            slcr_pkg::SLCR_SEL_HIZ:      pin_oe_d = 1'h0; // R1
            slcr_pkg::SLCR_SEL_HIGH:     pin_o_d = 1'h1; // R2
            slcr_pkg::SLCR_SEL_LOW:      pin_o_d = 1'h0; // R2
            slcr_pkg::SLCR_SEL_DL_BOTH:
                pin_o_d = lock.main_dig & lock.aux_dig; // R3
            slcr_pkg::SLCR_SEL_DL_MAIN:  pin_o_d = lock.main_dig; // R3
            slcr_pkg::SLCR_SEL_DL_AUX:   pin_o_d = lock.aux_dig; // R3
            // Open drain pulls low while unlocked and floats when locked.
            slcr_pkg::SLCR_SEL_AOD_BOTH:
                pin_oe_d = ~(lock.main_ana & lock.aux_ana); // R4
            slcr_pkg::SLCR_SEL_AOD_MAIN: pin_oe_d = ~lock.main_ana; // R4
            slcr_pkg::SLCR_SEL_AOD_AUX:  pin_oe_d = ~lock.aux_ana; // R4
            slcr_pkg::SLCR_SEL_APP_BOTH:
                pin_o_d = lock.main_ana & lock.aux_ana; // R4
            slcr_pkg::SLCR_SEL_APP_MAIN: pin_o_d = lock.main_ana; // R4
            slcr_pkg::SLCR_SEL_APP_AUX:  pin_o_d = lock.aux_ana; // R4
            slcr_pkg::SLCR_SEL_AUX_REF:  pin_o_d = half_q[0]; // R5
            slcr_pkg::SLCR_SEL_AUX_FB:   pin_o_d = half_q[1]; // R5
            slcr_pkg::SLCR_SEL_MAIN_REF: pin_o_d = half_q[2]; // R5
            slcr_pkg::SLCR_SEL_MAIN_FB:  pin_o_d = half_q[3]; // R5
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half_q <= 4'h0;
            pin_o  <= 1'h0;
            pin_oe <= 1'h0;
        end else begin
            half_q <= half_d;
            pin_o  <= pin_o_d;
            pin_oe <= pin_oe_d;
        end
    end
endmodule

// ### slcr_ref_path.sv
// Purpose: Reference buffer output and reference divider feeds.
// Assumes: The reference input is sampled as a synchronous level.
// Notes:   The doubled feed marks both edges of the reference.
`timescale 1ns/1ps
module slcr_ref_path (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Controls.
    input  wire logic doubler_en,
    input  wire logic buf_en,
    // Reference.
    input  wire logic ref_in,
    output logic      ref_out_o,
    output logic      ref_out_oe,
    output logic      main_ref_feed,
    output logic      aux_ref_feed
);
    logic prev_q;
    logic rise;
    logic fall;

    always_comb begin
        rise = ref_in & ~prev_q;
        fall = ~ref_in & prev_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_q        <= 1'h0;
            ref_out_o     <= 1'h0;
            ref_out_oe    <= 1'h0;
            main_ref_feed <= 1'h0;
            aux_ref_feed  <= 1'h0;
        end else begin
            prev_q        <= ref_in;
            ref_out_o     <= ref_in & buf_en; // R9
            ref_out_oe    <= buf_en; // R9
            main_ref_feed <= rise | (fall & doubler_en); // R10
            aux_ref_feed  <= rise; // R10
        end
    end
endmodule

// ### slcr_top.sv
// Purpose: Loop configuration and extended fraction register bank.
// Assumes: A latched serial word arrives whole with a one-cycle strobe.
// Notes:   Words with other addresses leave these registers unchanged.
//
// Contract
// R1 - Selector zero floats the test and lock pin.
// R2 - Codes 1 and 2 drive the pin high or low push-pull.
// R3 - Codes 3 to 5 drive digital lock: both, main, auxiliary.
// R4 - Codes 6 to 8 analog lock open drain; 9 to 11 push-pull.
// R5 - Codes 12 to 15 output halved divider outputs in fixed order.
// R6 - Prescaler bit 0 selects 8/9, bit 1 selects 16/17.
// R7 - Main pump negative at 0, positive at 1, positive by default.
// R8 - Auxiliary pump positive at 1, negative at 0; host usually writes 1.
// R9 - Buffer bit 0 floats reference output; 1 drives buffered reference.
// R10 - Doubler bit 1 feeds the main reference divider twice the rate.
// R11 - Order 0 fourth, 2 second, 3 third order modulation.
// R12 - Order 1 bypasses the modulator; for test only.
// R13 - Dither 0 off, 1 weak, 2 strong, 3 reserved.
// R14 - Host should use denominator of at least 1000 with dither.
// R15 - With auto power-up set, frequency writes clear both power-downs.
// R16 - Auto power-up is suppressed while chip enable is low.
// R17 - Extended word bits 23:14 give denominator bits 21:12.
// R18 - Extended word bits 13:4 give numerator bits 21:12.
// R19 - Configuration fields sit at their fixed bit positions.
// R20 - Low nibble addresses the word; 1001 config, 1011 extended.
// R21 - Host writes bit 21 as one, bits 22,20,19,18,13 zero.
`timescale 1ns/1ps
`include "slcr_defs.svh"
module slcr_top (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Latched serial word.
    input  wire logic [23:0]           word_data,
    input  wire logic                  word_latch,
    // Chip enable pin.
    input  wire logic                  chip_en,
    // Loop status and divider outputs.
    input  wire slcr_pkg::slcr_lock_t  lock,
    input  wire slcr_pkg::slcr_div_t   div_pulse,
    // Reference input.
    input  wire logic                  ref_in,
    // Test and lock indication pin.
    output logic                       test_lock_out_pin_o,
    output logic                       test_lock_out_pin_oe,
    // Reference output pin.
    output logic                       ref_out_pin_o,
    output logic                       ref_out_pin_oe,
    // Reference divider feeds.
    output logic                       main_ref_feed,
    output logic                       aux_ref_feed,
    // Loop controls.
    output logic                       aux_prescaler_16,
    output logic                       main_pump_polarity,
    output logic                       aux_pump_polarity,
    output logic                       ref_doubler_en,
    output logic                       ref_buffer_out_en,
    output slcr_pkg::slcr_order_t      modulator_order_sel,
    output logic                       modulator_bypass,
    output slcr_pkg::slcr_dither_t     spur_spread_sel,
    output logic                       dither_weak,
    output logic                       dither_strong,
    output logic                       auto_powerup_on_write,
    // Power-down clear toward the power control register.
    output logic                       powerdown_clear,
    // Extended fraction.
    output logic [9:0]                 ext_frac_den_hi,
    output logic [9:0]                 ext_frac_num_hi,
    // Write events and fixed-bit status.
    output logic                       loop_config_written,
    output logic                       ext_fraction_written,
    output logic                       fixed_bits_error
);

    function automatic logic [3:0] word_addr(input logic [23:0] w);
        word_addr = w[`SLCR_ADDR_MSB:`SLCR_ADDR_LSB];
    endfunction

    function automatic logic is_write(input logic        latch,
                                      input logic [23:0] w,
                                      input logic [3:0]  addr);
        is_write = latch & (word_addr(w) == addr);
    endfunction

    function automatic slcr_pkg::slcr_cfg_t cfg_reset();
        slcr_pkg::slcr_cfg_t c;
        c.auto_pu  = `SLCR_RST_AUTO_PU;
        c.dither   = slcr_pkg::slcr_dither_t'(`SLCR_RST_DITHER);
        c.order    = slcr_pkg::slcr_order_t'(`SLCR_RST_ORDER);
        c.doubler  = `SLCR_RST_DOUBLER;
        c.ref_buf  = `SLCR_RST_REFBUF;
        c.aux_pol  = `SLCR_RST_AUXPOL;
        c.main_pol = `SLCR_RST_MAINPOL;
        c.presc    = `SLCR_RST_PRESC;
        c.out_sel  = slcr_pkg::slcr_sel_t'(`SLCR_RST_OUTSEL);
        cfg_reset = c;
    endfunction

    slcr_pkg::slcr_cfg_t cfg_q;
    slcr_pkg::slcr_cfg_t cfg_d;
    logic [9:0]          den_q;
    logic [9:0]          den_d;
    logic [9:0]          num_q;
    logic [9:0]          num_d;
    logic                fixed_err_q;
    logic                fixed_err_d;

    logic                pd_clear_q;
    logic                pd_clear_d;
    logic                cfg_wr_q;
    logic                cfg_wr_d;
    logic                ext_wr_q;
    logic                ext_wr_d;

    logic                wr_cfg;
    logic                wr_ext;
    logic                wr_freq;

    always_comb begin
        wr_cfg  = is_write(word_latch, word_data, `SLCR_ADDR_LOOP_CFG); // R20
        wr_ext  = is_write(word_latch, word_data, `SLCR_ADDR_EXT_FRAC); // R20
        wr_freq = is_write(word_latch, word_data, `SLCR_ADDR_FREQ_WORD);
    end

    always_comb begin
        cfg_d       = cfg_q;
        den_d       = den_q;
        num_d       = num_q;
        fixed_err_d = fixed_err_q;
        if (wr_cfg) begin
            cfg_d.auto_pu  = word_data[`SLCR_AUTO_PU_BIT]; // R19
            cfg_d.dither   = slcr_pkg::slcr_dither_t'(
                word_data[`SLCR_DITHER_MSB:`SLCR_DITHER_LSB]); // R19
            cfg_d.order    = slcr_pkg::slcr_order_t'(
                word_data[`SLCR_ORDER_MSB:`SLCR_ORDER_LSB]); // R19
            cfg_d.doubler  = word_data[`SLCR_DOUBLER_BIT]; // R19
            cfg_d.ref_buf  = word_data[`SLCR_REFBUF_BIT]; // R19
            cfg_d.aux_pol  = word_data[`SLCR_AUXPOL_BIT]; // R19
            cfg_d.main_pol = word_data[`SLCR_MAINPOL_BIT]; // R19
            cfg_d.presc    = word_data[`SLCR_PRESC_BIT]; // R19
            cfg_d.out_sel  = slcr_pkg::slcr_sel_t'(
                word_data[`SLCR_OUTSEL_MSB:`SLCR_OUTSEL_LSB]); // R19
            // Flags a word whose fixed bits the host got wrong.
            fixed_err_d = (word_data & `SLCR_FIXED_MASK)
                          != `SLCR_FIXED_VALUE; // R21
        end
        if (wr_ext) begin
            den_d = word_data[`SLCR_DEN_MSB:`SLCR_DEN_LSB]; // R17
            num_d = word_data[`SLCR_NUM_MSB:`SLCR_NUM_LSB]; // R18
        end
    end

    always_comb begin
        // The setting in force when the frequency word lands decides.
        pd_clear_d = wr_freq & cfg_q.auto_pu & chip_en; // R15 R16
        cfg_wr_d   = wr_cfg;
        ext_wr_d   = wr_ext;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q       <= cfg_reset();
            den_q       <= `SLCR_RST_FRAC;
            num_q       <= `SLCR_RST_FRAC;
            fixed_err_q <= 1'h0;
        end else begin
            cfg_q       <= cfg_d;
            den_q       <= den_d;
            num_q       <= num_d;
            fixed_err_q <= fixed_err_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_clear_q <= 1'h0;
            cfg_wr_q   <= 1'h0;
            ext_wr_q   <= 1'h0;
        end else begin
            pd_clear_q <= pd_clear_d;
            cfg_wr_q   <= cfg_wr_d;
            ext_wr_q   <= ext_wr_d;
        end
    end

    always_comb begin
        aux_prescaler_16      = cfg_q.presc; // R6
        main_pump_polarity    = cfg_q.main_pol; // R7
        aux_pump_polarity     = cfg_q.aux_pol; // R8
        ref_doubler_en        = cfg_q.doubler;
        ref_buffer_out_en     = cfg_q.ref_buf;
        modulator_order_sel   = cfg_q.order; // R11
        modulator_bypass      = cfg_q.order == slcr_pkg::SLCR_BYPASS; // R12
        spur_spread_sel       = cfg_q.dither; // R13
        // The reserved dither code leaves both strengths off.
        dither_weak   = cfg_q.dither == slcr_pkg::SLCR_SPUR_SPREAD_SEL_WEAK; // R13
        dither_strong = cfg_q.dither == slcr_pkg::SLCR_SPUR_SPREAD_SEL_STRONG; // R13
        auto_powerup_on_write = cfg_q.auto_pu;
        powerdown_clear       = pd_clear_q;
        ext_frac_den_hi       = den_q;
        ext_frac_num_hi       = num_q;
        loop_config_written   = cfg_wr_q;
        ext_fraction_written  = ext_wr_q;
        fixed_bits_error      = fixed_err_q;
    end

    slcr_pin_mux u_pin_mux (
        .clk       (clk),
        .rst       (rst),
        .sel       (cfg_q.out_sel),
        .lock      (lock),
        .div_pulse (div_pulse),
        .pin_o     (test_lock_out_pin_o),
        .pin_oe    (test_lock_out_pin_oe)
    );

    slcr_ref_path u_ref_path (
        .clk           (clk),
        .rst           (rst),
        .doubler_en    (cfg_q.doubler),
        .buf_en        (cfg_q.ref_buf),
        .ref_in        (ref_in),
        .ref_out_o     (ref_out_pin_o),
        .ref_out_oe    (ref_out_pin_oe),
        .main_ref_feed (main_ref_feed),
        .aux_ref_feed  (aux_ref_feed)
    );

endmodule

// ### slcr_host_model.sv
// Purpose: Host writing latched words.
// Assumes: Calls start at a falling edge.
// Notes:   Released data is inverted so stale words look wrong.
`timescale 1ns/1ps
module slcr_host_model (
    // Clock.
    input  wire logic   clk,
    // Serial word toward the device.
    output logic [23:0] word_data,
    output logic        word_latch
);
    initial begin
        word_data  = 24'h5a5a5a;
        word_latch = 1'b0;
    end

    // Fixed bits are always written with their required values.
    function automatic logic [23:0] cfg_word(input logic au,
        input logic [1:0] di, input logic [1:0] od, input logic db,
        input logic bf, input logic ap, input logic mp, input logic ps,
        input logic [3:0] sl);
        return {au, 3'h2, 2'h0, di, od, 1'b0, db, bf, ap, mp, ps, sl,
                4'h9};
    endfunction

    // Holds one word for one clock.
    task automatic send(input logic [23:0] w);
        word_data  = w;
        word_latch = 1'b1;
        @(negedge clk);
    endtask

    task automatic idle;
        word_data  = ~word_data;
        word_latch = 1'b0;
    endtask
endmodule

// ### slcr_top_asserts.sv
// Purpose: Port checks of the bank.
// Assumes: One clock, reset active high.
// Notes:   Bound to the top module.
`timescale 1ns/1ps
module slcr_top_asserts (
    // Clock and reset.
    input wire logic                   clk,
    input wire logic                   rst,
    // Inputs.
    input wire logic [23:0]            word_data,
    input wire logic                   word_latch,
    input wire logic                   chip_en,
    input wire logic                   ref_in,
    // Outputs.
    input wire logic                   test_lock_out_pin_oe,
    input wire logic                   ref_out_pin_o,
    input wire logic                   ref_out_pin_oe,
    input wire logic                   aux_prescaler_16,
    input wire logic                   main_pump_polarity,
    input wire logic                   aux_pump_polarity,
    input wire logic                   ref_buffer_out_en,
    input wire slcr_pkg::slcr_order_t  modulator_order_sel,
    input wire logic                   modulator_bypass,
    input wire slcr_pkg::slcr_dither_t spur_spread_sel,
    input wire logic                   dither_weak,
    input wire logic                   dither_strong,
    input wire logic                   auto_powerup_on_write,
    input wire logic                   powerdown_clear,
    input wire logic [9:0]             ext_frac_den_hi,
    input wire logic [9:0]             ext_frac_num_hi,
    input wire logic                   loop_config_written,
    input wire logic                   ext_fraction_written
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    wire cfg_w = word_latch && (word_data[3:0] == 4'h9);
    wire ext_w = word_latch && (word_data[3:0] == 4'hb);
    wire pu_w  = word_latch && (word_data[3:0] == 4'h0) && chip_en
                 && auto_powerup_on_write;

    property p_presc;
        cfg_w |=> aux_prescaler_16 == $past(word_data[8]);
    endproperty
    a_presc: assert property (p_presc)
        else $error("prescaler wrong");
    property p_mainpol;
        cfg_w |=> main_pump_polarity == $past(word_data[9]);
    endproperty
    a_mainpol: assert property (p_mainpol)
        else $error("main polarity wrong");
    property p_auxpol;
        cfg_w |=> aux_pump_polarity == $past(word_data[10]);
    endproperty
    a_auxpol: assert property (p_auxpol)
        else $error("aux polarity wrong");
    property p_order;
        cfg_w |=> modulator_order_sel == $past(word_data[15:14]);
    endproperty
    a_order: assert property (p_order)
        else $error("order wrong");
    property p_bypass;
        modulator_bypass == (modulator_order_sel == 2'h1);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass wrong");
    property p_dither;
        {dither_weak, dither_strong} ==
        {spur_spread_sel == 2'h1, spur_spread_sel == 2'h2};
    endproperty
    a_dither: assert property (p_dither)
        else $error("dither wrong");
    property p_frac;
        ext_w |=> {ext_frac_den_hi, ext_frac_num_hi} ==
                  $past(word_data[23:4]) && ext_fraction_written;
    endproperty
    a_frac: assert property (p_frac)
        else $error("fraction wrong");
    property p_pu;
        powerdown_clear == $past(pu_w);
    endproperty
    a_pu: assert property (p_pu)
        else $error("power-up pulse wrong");
    property p_written;
        loop_config_written == $past(cfg_w);
    endproperty
    a_written: assert property (p_written)
        else $error("write pulse wrong");
    property p_hiz;
        cfg_w && word_data[7:5] == 3'h0 |->
            ##2 test_lock_out_pin_oe == $past(word_data[4], 2);
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("pin enable wrong");
    property p_refbuf;
        ##1 ref_out_pin_oe == $past(ref_buffer_out_en) &&
            ref_out_pin_o == $past(ref_in & ref_buffer_out_en);
    endproperty
    a_refbuf: assert property (p_refbuf)
        else $error("reference pin wrong");
endmodule

bind slcr_top slcr_top_asserts u_chk (.*);

// ### tb_top.sv
// Purpose: Self-checking bench of the bank.
// Assumes: Inputs change at falling edges.
// Notes:   Fixed seed.
`timescale 1ns/1ps
module tb_top;
    logic clk, rst, chip_en, ref_in, word_latch;
    logic [23:0] word_data;
    slcr_pkg::slcr_lock_t lock;
    slcr_pkg::slcr_div_t  div_pulse;
    logic test_lock_out_pin_o, test_lock_out_pin_oe, ref_out_pin_o;
    logic ref_out_pin_oe, main_ref_feed, aux_ref_feed, aux_prescaler_16;
    logic main_pump_polarity, aux_pump_polarity, ref_doubler_en;
    logic ref_buffer_out_en, modulator_bypass, dither_weak, dither_strong;
    logic auto_powerup_on_write, powerdown_clear, loop_config_written;
    logic ext_fraction_written, fixed_bits_error;
    slcr_pkg::slcr_order_t  modulator_order_sel;
    slcr_pkg::slcr_dither_t spur_spread_sel;
    logic [9:0] ext_frac_den_hi, ext_frac_num_hi;
    logic [31:0] f;
    logic [23:0] w, e1, e2;
    logic [3:0] sel;
    logic p0;
    int err_count, cmp_count, na, nm;

    slcr_top dut (.*);
    slcr_host_model host (.clk, .word_data, .word_latch);

    initial clk = 1'b0;
    always #2 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string m);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [23:0] x);
        host.send(x);
        host.idle();
    endtask

    // Expected pin {value, enable}; selector 0 leaves value unchecked.
    function automatic logic [1:0] exp_pin(input logic [3:0] s,
                                           input slcr_pkg::slcr_lock_t k);
        logic [2:0] d, a;
        d = {k.main_dig & k.aux_dig, k.main_dig, k.aux_dig};
        a = {k.main_ana & k.aux_ana, k.main_ana, k.aux_ana};
        case (s)
            4'h1, 4'h2: return {s == 4'h1, 1'b1};
            4'h3, 4'h4, 4'h5: return {d[4'h5 - s], 1'b1};
            4'h6, 4'h7, 4'h8: return {1'b0, ~a[4'h8 - s]};
            4'h9, 4'ha, 4'hb: return {a[4'hb - s], 1'b1};
            default: return 2'b00;
        endcase
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("unexpected at %0t: run timed out", $time);
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        chip_en = 1'b1;
        ref_in = 1'b0;
        lock = 4'h0;
        div_pulse = 4'h0;
        void'($urandom(32'hf15d));
        cyc(10);
        rst = 1'b0;
        chk({auto_powerup_on_write, spur_spread_sel, modulator_order_sel,
             ref_doubler_en, ref_buffer_out_en, aux_pump_polarity,
             main_pump_polarity, aux_prescaler_16}, 10'h167, "defaults");
        chk({ext_frac_den_hi, ext_frac_num_hi, test_lock_out_pin_oe,
             ref_out_pin_oe, fixed_bits_error}, 0, "reset state");
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            f = $urandom;
            sel = i[3:0];
            lock = 4'(f[17:14]);
            w = host.cfg_word(f[0], f[2:1], f[4:3], f[5], f[6], f[7],
                              f[8], f[9], sel);
            wr(w);
            chk(loop_config_written, 1, "config pulse");
            chk({aux_prescaler_16, main_pump_polarity, aux_pump_polarity,
                 ref_doubler_en, ref_buffer_out_en}, {f[9], f[8], f[7],
                 f[5], f[6]}, "control bits");
            chk({modulator_order_sel, modulator_bypass},
                {f[4:3], f[4:3] == 2'h1}, "order");
            chk({spur_spread_sel, dither_weak, dither_strong},
                {f[2:1], f[2:1] == 2'h1, f[2:1] == 2'h2}, "dither");
            chk({auto_powerup_on_write, fixed_bits_error}, {f[0], 1'b0},
                "power-up bit");
            cyc(1);
            if (i < 12) begin
                chk({test_lock_out_pin_o & (sel != 4'h0),
                     test_lock_out_pin_oe}, exp_pin(sel, lock),
                    "pin");
            end else begin
                p0 = test_lock_out_pin_o;
                div_pulse = 4'hf ^ (4'h1 << (i - 12));
                cyc(1);
                div_pulse = 4'h0;
                cyc(3);
                chk(test_lock_out_pin_o, p0, "unselected divider");
                div_pulse = 4'h1 << (i - 12);
                cyc(1);
                div_pulse = 4'h0;
                cyc(3);
                chk({test_lock_out_pin_o, test_lock_out_pin_oe},
                    {~p0, 1'b1}, "divider copy");
            end
        end
        wr(w ^ 24'h200000);
        chk(fixed_bits_error, 1, "fixed bits");
        cyc(1);
        wr({~w[23:4], 4'h8});
        chk({loop_config_written, aux_prescaler_16}, {1'b0, w[8]},
            "foreign address");
        $display("test config done");
        f = $urandom;
        e1 = {10'(f) | 10'h1, f[31:22], 4'hb};
        e2 = {~e1[23:4], 4'hb};
        cyc(1);
        host.send(e1);
        chk({ext_frac_den_hi, ext_frac_num_hi}, e1[23:4], "first");
        host.send(e2);
        chk({ext_frac_den_hi, ext_frac_num_hi, ext_fraction_written},
            {e2[23:4], 1'b1}, "second");
        host.idle();
        cyc(1);
        $display("test fraction done");
        for (int j = 0; j < 3; j++) begin
            wr(host.cfg_word(j != 2, 2'h2, 2'h3, 1'b0, 1'b0, 1'b1, 1'b1,
                             1'b1, 4'h0));
            chip_en = (j != 1);
            cyc(1);
            host.send({20'($urandom), 4'h0});
            chk(powerdown_clear, j == 0, "power-up pulse");
            host.idle();
            cyc(1);
            chk(powerdown_clear, 0, "power-up width");
        end
        chip_en = 1'b1;
        $display("test power-up done");
        for (int j = 0; j < 2; j++) begin
            wr(host.cfg_word(1'b0, 2'h2, 2'h3, j[0], j[0], 1'b1, 1'b1,
                             1'b1, 4'h0));
            cyc(2);
            chk(ref_out_pin_oe, j, "reference enable");
            na = 0;
            nm = 0;
            for (int t = 0; t < 43; t++) begin
                if (t < 40 && t % 2 == 0)
                    ref_in = ~ref_in;
                cyc(1);
                na += aux_ref_feed;
                nm += main_ref_feed;
            end
            chk(na, 10, "aux feed count");
            chk(nm, j ? 20 : 10, "main feed count");
        end
        $display("test reference done");
        print_verdict();
    end
endmodule
